// [audio_transport_pkg.sv]
package audio_transport_pkg;

	// APB register byte offsets
	localparam logic [7:0] CTRL_OFFSET      = 8'h00;
	localparam logic [7:0] PIXCLK_OFFSET    = 8'h04;
	localparam logic [7:0] STATUS_OFFSET    = 8'h08;
	localparam logic [7:0] TXCOUNT_OFFSET   = 8'h0C;
	localparam logic [7:0] CLEAR_OFFSET     = 8'h10;

	// Control register field positions
	localparam int CTRL_SURROUND_BIT = 0;
	localparam int CTRL_ISLAND_BIT   = 1;
	localparam int CTRL_FOURCH_BIT   = 2;
	localparam int CTRL_TDM_BIT      = 3;
	localparam int CTRL_TDM8_BIT     = 4;
	localparam int CTRL_AUX_BIT      = 5;
	localparam int CTRL_EMBED_BIT    = 6;
	localparam int CTRL_DUAL_BIT     = 7;
	localparam int CTRL_WLEN_LSB     = 8;
	localparam int CTRL_WLEN_W       = 7;

	// Surround and island transport on, embedded audio on, dual lane on, 24-bit slots
	localparam logic [31:0] CTRL_RESET   = 32'h0000_18C3;
	localparam logic [7:0]  PIXCLK_RESET = 8'h00;

	// Compatibility window for legacy partners, input video clock in MHz
	localparam logic [7:0] LEGACY_MIN_MHZ = 8'd25;
	localparam logic [7:0] LEGACY_MAX_MHZ = 8'd96;

	// TDM: 256 bit clocks per frame, four slots up to 64 bits or eight up to 32
	localparam int          TDM_FRAME_BITS = 256;
	localparam logic [3:0]  TDM_SLOTS_WIDE = 4'd4;
	localparam logic [3:0]  TDM_SLOTS_NARROW = 4'd8;
	localparam logic [6:0]  WORD_STORE_BITS = 7'd32;
	localparam logic [6:0]  BITCNT_MAX = 7'h7F;

	// Partner kind as reported by link detection
	localparam logic [1:0] PARTNER_NONE        = 2'd0;
	localparam logic [1:0] PARTNER_NEW         = 2'd1;
	localparam logic [1:0] PARTNER_LEGACY      = 2'd2;
	localparam logic [1:0] PARTNER_LEGACY_SURR = 2'd3;

	// Source numbering on the link tag
	localparam int SRC_COUNT = 6;
	localparam int LANE_COUNT = 5;
	localparam logic [2:0] SRC_AUX   = 3'd4;
	localparam logic [2:0] SRC_EMBED = 3'd5;

endpackage

// [audio_transport.sv]
// The register offsets and the APB register port were decided locally.
`timescale 1ns/1ps
// Function
// RL1: Legacy partners served only while pixel clock is within 25 to 96 MHz.
// RL2: Legacy partner detected forces single-lane output on the primary pair.
// RL3: Legacy surround-default partner with surround enabled gets 18-bit video.
// RL4: Host clears surround enable to restore 24-bit video to that partner.
// RL5: Embedded video audio samples are carried over the forward link.
// RL6: Source keeps bit clock between 1 MHz and min of pixel/2, 13 MHz.
// RL7: Four data inputs, two channels each, split by shared word select level.
// RL8: Source runs bit clock at twice word size times sample rate.
// RL9: Default transport packs audio into data islands sent only in blanking.
// RL10: Islands off: frame transport sends A to new, A and B to legacy.
// RL11: Surround carries all four inputs, islands only, new partners only.
// RL12: Upstream repeater surround request forces surround over islands.
// RL13: Host sets four-channel A/B mode explicitly in every repeater node.
// RL14: Auxiliary audio channel uses GPIO0/GPIO1 pins, sent independently.
// RL15: TDM input with configurable word length and channel count.
// RL16: 256-bit TDM frame gives four 64-bit or eight 32-bit slots.
// RL17: Sample on bit clock rising edge; first bit after select change is MSB.
module audio_transport
	import audio_transport_pkg::*;
(
	input  wire logic        CLK,                // 20 MHz system clock
	input  wire logic        RST_N,              // Synchronous reset, active low
	input  wire logic        PSEL,               // APB select
	input  wire logic        PENABLE,            // APB access phase
	input  wire logic        PWRITE,             // APB direction
	input  wire logic [7:0]  PADDR,              // APB byte address
	input  wire logic [31:0] PWDATA,             // APB write data
	output logic      [31:0] PRDATA,             // APB read data
	output logic             PREADY,             // APB ready
	output logic             PSLVERR,            // APB error, unmapped address
	input  wire logic        AUDIO_BIT_CLK,      // Serial audio bit clock pin
	input  wire logic        AUDIO_WORD_SELECT,  // Shared word select pin
	input  wire logic        AUDIO_DATA_A,       // Serial audio data A
	input  wire logic        AUDIO_DATA_B,       // Serial audio data B
	input  wire logic        AUDIO_DATA_C,       // Serial audio data C
	input  wire logic        AUDIO_DATA_D,       // Serial audio data D
	input  wire logic [1:0]  GPIO_IN,            // GPIO pins, aux data and aux select
	input  wire logic [1:0]  PARTNER_KIND,       // Detected deserializer kind
	input  wire logic        RPT_SURROUND_REQ,   // Surround request from upstream
	input  wire logic        VIDEO_BLANKING,     // Video blanking interval, same clock
	input  wire logic        EMB_VALID,          // Embedded audio sample strobe
	input  wire logic [31:0] EMB_SAMPLE,         // Embedded audio sample
	input  wire logic [2:0]  EMB_CHAN,           // Embedded audio channel
	input  wire logic        LINK_READY,         // Link accepts a word
	output logic             LINK_VALID,         // Link word valid
	output logic      [31:0] LINK_WORD,          // Audio word to link
	output logic      [2:0]  LINK_SRC,           // Source lane of word
	output logic      [2:0]  LINK_CHAN,          // Channel or slot of word
	output logic             LINK_ISLAND,        // Word travels in a data island
	output logic             SINGLE_LANE,        // Primary serial output only
	output logic             VIDEO_18BIT         // Video reduced to 18-bit colour
);

	// Pin synchronisers: stage one feeds stage two only
	logic [10:0] sync1_ff;
	logic [10:0] sync2_ff;
	logic        bclk_prev_ff;
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			sync1_ff     <= '0;
			sync2_ff     <= '0;
			bclk_prev_ff <= 1'b0;
		end else begin
			sync1_ff     <= {RPT_SURROUND_REQ, PARTNER_KIND, GPIO_IN, AUDIO_DATA_D, AUDIO_DATA_C,
				AUDIO_DATA_B, AUDIO_DATA_A, AUDIO_WORD_SELECT, AUDIO_BIT_CLK};
			sync2_ff     <= sync1_ff;
			bclk_prev_ff <= sync2_ff[0];
		end
	end

	logic       ws_main;
	logic [4:0] lane_bit;
	logic [4:0] lane_ws;
	logic [1:0] partner;
	logic       rpt_surr;
	// RL17: rising edge sample
	logic       bclk_rise;
	assign bclk_rise = sync2_ff[0] & ~bclk_prev_ff;
	assign ws_main   = sync2_ff[1];
	assign partner   = sync2_ff[9:8];
	assign rpt_surr  = sync2_ff[10];
	// RL14: aux data on GPIO0, aux select on GPIO1
	assign lane_bit  = {sync2_ff[6], sync2_ff[5:2]};
	assign lane_ws   = {sync2_ff[7], {4{ws_main}}};

	// Registers
	logic [31:0] ctrl_ff;
	logic [7:0]  pixclk_ff;
	logic        overrun_ff;
	logic [31:0] txcount_ff;
	logic        apb_done;
	logic        addr_ok;
	assign apb_done = PSEL & PENABLE & PREADY;
	assign addr_ok  = (PADDR == CTRL_OFFSET) || (PADDR == PIXCLK_OFFSET) || (PADDR == STATUS_OFFSET) ||
		(PADDR == TXCOUNT_OFFSET) || (PADDR == CLEAR_OFFSET);

	logic       surround_en;
	logic       island_en;
	logic       tdm_en;
	logic       aux_en;
	logic [6:0] wlen;
	assign surround_en = ctrl_ff[CTRL_SURROUND_BIT];
	assign island_en   = ctrl_ff[CTRL_ISLAND_BIT];
	assign tdm_en      = ctrl_ff[CTRL_TDM_BIT];
	assign aux_en      = ctrl_ff[CTRL_AUX_BIT];
	assign wlen        = ctrl_ff[CTRL_WLEN_LSB +: CTRL_WLEN_W];

	// Effective transport mode
	logic partner_new;
	logic partner_legacy;
	logic compat_ok;
	logic island_eff;
	logic surround_eff;
	logic [3:0] max_slots;
	assign partner_new    = (partner == PARTNER_NEW);
	assign partner_legacy = (partner == PARTNER_LEGACY) || (partner == PARTNER_LEGACY_SURR);
	// RL1: legacy window check
	assign compat_ok      = !partner_legacy || ((pixclk_ff >= LEGACY_MIN_MHZ) && (pixclk_ff <= LEGACY_MAX_MHZ));
	// RL12: repeater request forces islands
	assign island_eff     = island_en | rpt_surr;
	// RL11: surround needs islands and new partner
	assign surround_eff   = (surround_en | rpt_surr) & island_eff & partner_new;
	// RL16: slot count by slot width
	assign max_slots      = ctrl_ff[CTRL_TDM8_BIT] ? TDM_SLOTS_NARROW : TDM_SLOTS_WIDE;

	// Lane deserialisers
	logic [31:0] sh_ff   [LANE_COUNT];
	logic [6:0]  cnt_ff  [LANE_COUNT];
	logic [3:0]  slot_ff [LANE_COUNT];
	logic        wsp_ff  [LANE_COUNT];
	logic [SRC_COUNT-1:0] cap;
	logic [31:0] cap_word [SRC_COUNT];
	logic [2:0]  cap_chan [SRC_COUNT];
	logic [31:0] shifted  [LANE_COUNT];

	// Word completion per lane, combinational
	always_comb begin
		for (int l = 0; l < LANE_COUNT; l++) begin
			shifted[l]  = {sh_ff[l][30:0], lane_bit[l]};
			cap[l]      = 1'b0;
			cap_word[l] = sh_ff[l];
			cap_chan[l] = {2'b00, wsp_ff[l]};
			if (bclk_rise) begin
				if (lane_ws[l] != wsp_ff[l]) begin
					// RL7: select level names the channel just ended
					cap[l] = !tdm_en && (cnt_ff[l] != 7'd0);
				end else if (tdm_en && (cnt_ff[l] + 7'd1 == wlen) && (slot_ff[l] < max_slots)) begin
					// RL15: slot complete at programmed length
					cap[l]      = 1'b1;
					cap_word[l] = (cnt_ff[l] < WORD_STORE_BITS) ? shifted[l] : sh_ff[l];
					cap_chan[l] = slot_ff[l][2:0];
				end
			end
		end
		// RL5: embedded audio enters as its own source
		cap[SRC_EMBED]      = EMB_VALID & ctrl_ff[CTRL_EMBED_BIT];
		cap_word[SRC_EMBED] = EMB_SAMPLE;
		cap_chan[SRC_EMBED] = EMB_CHAN;
	end

	// Shift state per lane; only the first 32 bits of a wide slot are kept
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			for (int l = 0; l < LANE_COUNT; l++) begin
				sh_ff[l]   <= '0;
				cnt_ff[l]  <= '0;
				slot_ff[l] <= '0;
				wsp_ff[l]  <= 1'b0;
			end
		end else if (bclk_rise) begin
			for (int l = 0; l < LANE_COUNT; l++) begin
				if (lane_ws[l] != wsp_ff[l]) begin
					// RL17: first bit after change is MSB
					sh_ff[l]   <= {31'h0000_0000, lane_bit[l]};
					cnt_ff[l]  <= 7'd1;
					slot_ff[l] <= '0;
					wsp_ff[l]  <= lane_ws[l];
				end else if (tdm_en && (cnt_ff[l] + 7'd1 == wlen)) begin
					sh_ff[l]   <= '0;
					cnt_ff[l]  <= '0;
					slot_ff[l] <= (slot_ff[l] < max_slots) ? slot_ff[l] + 4'd1 : slot_ff[l];
				end else begin
					sh_ff[l]   <= (cnt_ff[l] < WORD_STORE_BITS) ? shifted[l] : sh_ff[l];
					cnt_ff[l]  <= (cnt_ff[l] == BITCNT_MAX) ? cnt_ff[l] : cnt_ff[l] + 7'd1;
				end
			end
		end
	end

	// Which sources may go out now
	logic [SRC_COUNT-1:0] lane_en;
	logic [SRC_COUNT-1:0] elig;
	always_comb begin
		lane_en[0] = 1'b1;
		// RL10: frame transport sends B only to legacy
		lane_en[1] = island_eff ? (ctrl_ff[CTRL_FOURCH_BIT] | surround_eff) : partner_legacy;
		// RL11: C and D only in surround
		lane_en[2] = surround_eff;
		lane_en[3] = surround_eff;
		// RL14: aux only to new partners
		lane_en[4] = aux_en & partner_new;
		lane_en[5] = island_eff;
		// RL9: islands only during blanking
		elig = (island_eff && !VIDEO_BLANKING) || !compat_ok || (partner == PARTNER_NONE) ? '0 : lane_en;
	end

	// Holding register per source; a new capture wins over a take
	logic [SRC_COUNT-1:0] pend_ff;
	logic [31:0] pword_ff [SRC_COUNT];
	logic [2:0]  pchan_ff [SRC_COUNT];
	logic [SRC_COUNT-1:0] take;
	logic [2:0]  take_src;
	logic        can_load;
	assign can_load = !LINK_VALID || LINK_READY;

	// Fixed priority: A, B, C, D, aux, embedded
	always_comb begin
		take     = '0;
		take_src = '0;
		for (int s = SRC_COUNT - 1; s >= 0; s--) begin
			if (can_load && pend_ff[s] && elig[s]) begin
				take     = '0;
				take[s]  = 1'b1;
				take_src = 3'(s);
			end
		end
	end

	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			pend_ff <= '0;
			for (int s = 0; s < SRC_COUNT; s++) begin
				pword_ff[s] <= '0;
				pchan_ff[s] <= '0;
			end
		end else begin
			pend_ff <= cap | (pend_ff & ~take);
			for (int s = 0; s < SRC_COUNT; s++) begin
				if (cap[s]) begin
					pword_ff[s] <= cap_word[s];
					pchan_ff[s] <= cap_chan[s];
				end
			end
		end
	end

	// Link word output, held until accepted
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			LINK_VALID  <= 1'b0;
			LINK_WORD   <= '0;
			LINK_SRC    <= '0;
			LINK_CHAN   <= '0;
			LINK_ISLAND <= 1'b0;
		end else if (can_load) begin
			LINK_VALID  <= |take;
			LINK_WORD   <= pword_ff[take_src];
			LINK_SRC    <= take_src;
			LINK_CHAN   <= pchan_ff[take_src];
			LINK_ISLAND <= island_eff;
		end
	end

	// Lane count and colour depth toward the video path
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			SINGLE_LANE <= 1'b1;
			VIDEO_18BIT <= 1'b0;
		end else begin
			// RL2: legacy partner uses one lane
			SINGLE_LANE <= partner_legacy | ~ctrl_ff[CTRL_DUAL_BIT];
			// RL3: surround-default legacy partner
			// RL4: cleared surround enable restores 24-bit
			VIDEO_18BIT <= (partner == PARTNER_LEGACY_SURR) & surround_en;
		end
	end

	// Overrun sticky and sent-word counter; a new overrun beats the clear
	logic clr_wr;
	assign clr_wr = apb_done && PWRITE && (PADDR == CLEAR_OFFSET) && PWDATA[0];
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			overrun_ff <= 1'b0;
			txcount_ff <= '0;
		end else begin
			overrun_ff <= |(cap & pend_ff & ~take) | (overrun_ff & ~clr_wr);
			txcount_ff <= (LINK_VALID && LINK_READY) ? txcount_ff + 32'd1 : txcount_ff;
		end
	end

	// Control writes
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			ctrl_ff   <= CTRL_RESET;
			pixclk_ff <= PIXCLK_RESET;
		end else if (apb_done && PWRITE) begin
			if (PADDR == CTRL_OFFSET) begin
				ctrl_ff <= {17'h0_0000, PWDATA[14:0]};
			end
			if (PADDR == PIXCLK_OFFSET) begin
				pixclk_ff <= PWDATA[7:0];
			end
		end
	end

	// APB answer: one wait cycle so read data comes from a flip-flop
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			PREADY  <= 1'b0;
			PRDATA  <= '0;
			PSLVERR <= 1'b0;
		end else if (PSEL && PENABLE && !PREADY) begin
			PREADY  <= 1'b1;
			PSLVERR <= !addr_ok;
			case (PADDR)
				CTRL_OFFSET:    PRDATA <= ctrl_ff;
				PIXCLK_OFFSET:  PRDATA <= {24'h00_0000, pixclk_ff};
				STATUS_OFFSET:  PRDATA <= {23'h00_0000, overrun_ff, compat_ok, surround_eff, island_eff,
					VIDEO_18BIT, SINGLE_LANE, rpt_surr, partner};
				TXCOUNT_OFFSET: PRDATA <= txcount_ff;
				default:        PRDATA <= '0;
			endcase
		end else begin
			PREADY  <= 1'b0;
			PSLVERR <= 1'b0;
		end
	end

endmodule

// [audio_transport_assertions.sv]
`timescale 1ns/1ps
module audio_transport_assertions
	import audio_transport_pkg::*;
(
	input logic        CLK,            // Clock
	input logic        RST_N,          // Reset
	input logic        PSEL,           // Select
	input logic        PENABLE,        // Access
	input logic        PREADY,         // Ready
	input logic        PSLVERR,        // Error
	input logic [1:0]  PARTNER_KIND,   // Partner
	input logic        VIDEO_BLANKING, // Blanking
	input logic        LINK_READY,     // Link accepts
	input logic        LINK_VALID,     // Word valid
	input logic [31:0] LINK_WORD,      // Word
	input logic [2:0]  LINK_SRC,       // Lane
	input logic [2:0]  LINK_CHAN,      // Channel
	input logic        LINK_ISLAND,    // Island
	input logic        SINGLE_LANE,    // One lane
	input logic        VIDEO_18BIT     // Reduced video
);
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RST_N);

	// Transfer phases and a freshly loaded island word
	sequence setup_s; PSEL && !PENABLE; endsequence
	sequence access_s; PSEL && PENABLE; endsequence
	sequence load_s; LINK_VALID && LINK_ISLAND && $past(!LINK_VALID || LINK_READY); endsequence

	a_ready_second: assert property (setup_s ##1 access_s |-> !PREADY ##1 PREADY)
		else $error("ready not in second access cycle");
	a_ready_pulse: assert property (PREADY |=> !PREADY)
		else $error("ready held too long");
	a_err_ready: assert property (PSLVERR |-> PREADY && PSEL && PENABLE)
		else $error("error outside completion");
	a_link_hold: assert property (LINK_VALID && !LINK_READY |=> LINK_VALID && $stable({LINK_WORD, LINK_SRC, LINK_CHAN}))
		else $error("link word dropped or changed");
	a_lane_legacy: assert property (PARTNER_KIND[1] [*8] |-> SINGLE_LANE)
		else $error("legacy partner not single lane");
	a_video_full: assert property ((PARTNER_KIND != 2'h3) [*8] |-> !VIDEO_18BIT)
		else $error("video reduced without cause");
	a_island_blank: assert property (load_s |-> $past(VIDEO_BLANKING))
		else $error("island word outside blanking");
	a_emb_island: assert property (LINK_VALID && LINK_SRC == SRC_EMBED |-> LINK_ISLAND)
		else $error("embedded audio outside island");
	a_surr_island: assert property (LINK_VALID && (LINK_SRC == 3'h2 || LINK_SRC == 3'h3) |-> LINK_ISLAND)
		else $error("lane C or D outside island");
	a_frame_lanes: assert property (LINK_VALID && !LINK_ISLAND |-> LINK_SRC <= 3'h1 || LINK_SRC == SRC_AUX)
		else $error("bad lane in frame transport");
endmodule

bind audio_transport audio_transport_assertions chk_i (.CLK(CLK), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE),
	.PREADY(PREADY), .PSLVERR(PSLVERR), .PARTNER_KIND(PARTNER_KIND), .VIDEO_BLANKING(VIDEO_BLANKING),
	.LINK_READY(LINK_READY), .LINK_VALID(LINK_VALID), .LINK_WORD(LINK_WORD), .LINK_SRC(LINK_SRC),
	.LINK_CHAN(LINK_CHAN), .LINK_ISLAND(LINK_ISLAND), .SINGLE_LANE(SINGLE_LANE), .VIDEO_18BIT(VIDEO_18BIT));

// [audio_source_model.sv]
`timescale 1ns/1ps
module audio_source_model (
	output logic       bclk, // Bit clock, still between frames
	output logic       ws,   // Word select, low for channel 0
	output logic [4:0] sd    // Data A to D, aux on bit 4
);
	// Idle lines at time zero
	initial begin
		bclk = 1'b0;
		ws = 1'b0;
		sd = 5'h00;
	end

	// 400 ns bit period, 48 clocks per stereo sample
	// data moves while the clock is low so the rise samples it
	// Non-blocking so that a change on a system clock edge never races the sampling flops
	task automatic put_bit(input logic s, input logic [4:0] d);
		bclk <= 1'b0;
		ws   <= s;
		sd   <= d;
		#200;
		bclk <= 1'b1;
		#200;
	endtask

	// Left then right 24-bit words, MSB first; a zero bit closes the right word
	task automatic send(input logic [4:0][23:0] l, input logic [4:0][23:0] r);
		logic [4:0] d;
		for (int i = 47; i >= 0; i--) begin
			for (int k = 0; k < 5; k++)
				d[k] = (i > 23) ? l[k][i - 24] : r[k][i];
			put_bit(i < 24, d);
		end
		put_bit(1'b0, 5'h00);
		// Clock stops; data lines are driven high so stale data never looks valid
		bclk <= 1'b0;
		sd   <= 5'h1F;
	endtask

	// TDM on data A: select rises with the first bit of slot 0 and holds
	task automatic send_tdm(input logic [8:0][23:0] w);
		for (int j = 0; j < 216; j++)
			put_bit(1'b1, {4'h0, w[j / 24][23 - j % 24]});
		put_bit(1'b0, 5'h00);
		bclk <= 1'b0;
		sd   <= 5'h1F;
	endtask
endmodule

// [tb.sv]
`timescale 1ns/1ps
module tb;
	import audio_transport_pkg::*;

	logic             clk;
	logic             rst_n = 1'b0;
	logic             psel = 1'b0;
	logic             penable = 1'b0;
	logic             pwrite = 1'b0;
	logic [7:0]       paddr = 8'h00;
	logic [31:0]      pwdata = 32'h0;
	logic             link_ready = 1'b1;
	logic             video_blanking = 1'b1;
	logic             emb_valid = 1'b0;
	logic [31:0]      emb_sample = 32'h0;
	logic [2:0]       emb_chan = 3'h0;
	logic [1:0]       partner_kind = 2'h1;
	logic [31:0]      seed = 32'hFD8EFBF0;
	logic [31:0]      stall = 32'hFD8EFBF0;
	logic             rpt_req = 1'b0;
	logic [8:0][23:0] tw;
	int               n_sent = 0;
	logic             pready, pslverr, link_valid, link_island, single_lane, video_18bit, bclk, ws, er;
	logic [2:0]       link_src, link_chan;
	logic [4:0]       sd;
	logic [31:0]      prdata, link_word, rd;
	logic [4:0][23:0] last_r;
	logic [38:0]      got[$];
	int               err_total = 0;
	int               num_checks = 0;

	audio_transport uut (.CLK(clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
		.PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
		.AUDIO_BIT_CLK(bclk), .AUDIO_WORD_SELECT(ws), .AUDIO_DATA_A(sd[0]), .AUDIO_DATA_B(sd[1]),
		.AUDIO_DATA_C(sd[2]), .AUDIO_DATA_D(sd[3]), .GPIO_IN({ws, sd[4]}), .PARTNER_KIND(partner_kind),
		.RPT_SURROUND_REQ(rpt_req), .VIDEO_BLANKING(video_blanking), .EMB_VALID(emb_valid),
		.EMB_SAMPLE(emb_sample), .EMB_CHAN(emb_chan), .LINK_READY(link_ready), .LINK_VALID(link_valid),
		.LINK_WORD(link_word), .LINK_SRC(link_src), .LINK_CHAN(link_chan), .LINK_ISLAND(link_island),
		.SINGLE_LANE(single_lane), .VIDEO_18BIT(video_18bit));
	audio_source_model src (.bclk(bclk), .ws(ws), .sd(sd));

	// 20 MHz system clock
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	function automatic logic [31:0] xs(ref logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction

	// Link stalls one cycle in four on average; accepted words are logged
	always @(posedge clk) begin
		link_ready <= (xs(stall) & 32'h3) != 32'h0;
		if (rst_n && link_valid && link_ready) begin
			got.push_back({link_src, link_chan, link_island, link_word});
			n_sent++;
		end
	end

	function automatic logic [38:0] pop();
		return (got.size() != 0) ? got.pop_front() : {39{1'bx}};
	endfunction

	task automatic give_verdict();
		$display("checks %0d errors %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	task automatic chk(input logic [38:0] g, input logic [38:0] e);
		num_checks++;
		if (g !== e) begin
			err_total++;
			$display("BAD at %0t got %h expected %h", $time, g, e);
		end
	endtask

	// Request stands until pready is seen high at an edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// One stereo sample; link words expected in lane priority order per channel
	task automatic frame(input logic [4:0] en, input logic isl);
		logic [4:0][23:0] l, r;
		for (int k = 0; k < 5; k++) begin
			l[k] = 24'(xs(seed));
			r[k] = 24'(xs(seed));
		end
		repeat (8) @(posedge clk);
		got.delete();
		src.send(l, r);
		last_r = r;
		repeat (60) @(posedge clk);
		for (int c = 0; c < 2; c++) begin
			for (int k = 0; k < 5; k++) begin
				if (en[k])
					chk(pop(), {3'(k), 3'(c), isl, 8'h00, c ? r[k] : l[k]});
			end
		end
		chk(39'(got.size()), 39'h0);
	endtask

	// Embedded sample, held back while blanking is low
	task automatic emb(input logic blank);
		logic [31:0] s;
		s = xs(seed);
		got.delete();
		@(posedge clk);
		video_blanking <= blank;
		emb_valid <= 1'b1;
		emb_sample <= s;
		emb_chan <= s[2:0];
		@(posedge clk);
		emb_valid <= 1'b0;
		repeat (10) @(posedge clk);
		chk(39'(got.size()), 39'(blank));
		video_blanking <= 1'b1;
		repeat (10) @(posedge clk);
		chk(pop(), {SRC_EMBED, s[2:0], 1'b1, s});
	endtask

	// Hang guard, about eight times the expected run
	initial begin
		repeat (40000) @(posedge clk);
		err_total++;
		give_verdict();
	end

	initial begin
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		apb(1'b0, CTRL_OFFSET, 32'h0);
		chk(39'(rd), 39'(CTRL_RESET));
		apb(1'b0, PIXCLK_OFFSET, 32'h0);
		chk(39'(rd), 39'(PIXCLK_RESET));
		apb(1'b0, 8'h20, 32'h0);
		chk({6'h00, er, rd}, {7'h01, 32'h0});
		chk(39'(single_lane), 39'h0);
		// Surround over islands with aux on
		apb(1'b1, CTRL_OFFSET, CTRL_RESET | 32'h20);
		frame(5'h1F, 1'b1);
		emb(1'b1);
		emb(1'b0);
		// Islands, surround off, four-channel A/B set by the host
		apb(1'b1, CTRL_OFFSET, (CTRL_RESET & 32'hFFFF_FFFE) | 32'h4);
		frame(5'h03, 1'b1);
		// Frame transport to a new, then a legacy partner
		apb(1'b1, CTRL_OFFSET, CTRL_RESET & 32'hFFFF_FFFC);
		frame(5'h01, 1'b0);
		// Repeater surround request turns on islands and all four lanes
		rpt_req <= 1'b1;
		repeat (20) @(posedge clk);
		frame(5'h0F, 1'b1);
		rpt_req <= 1'b0;
		partner_kind <= 2'h2;
		apb(1'b1, PIXCLK_OFFSET, 32'h32);
		frame(5'h03, 1'b0);
		chk(39'(single_lane), 39'h1);
		// Pixel clock just above the window, then on its lower bound
		apb(1'b1, PIXCLK_OFFSET, 32'h61);
		frame(5'h00, 1'b0);
		apb(1'b1, PIXCLK_OFFSET, 32'h19);
		repeat (20) @(posedge clk);
		chk(pop(), {6'h01, 1'b0, 8'h00, last_r[0]});
		chk(pop(), {6'h09, 1'b0, 8'h00, last_r[1]});
		partner_kind <= 2'h3;
		apb(1'b1, CTRL_OFFSET, CTRL_RESET);
		repeat (8) @(posedge clk);
		chk(39'(video_18bit), 39'h1);
		apb(1'b1, CTRL_OFFSET, CTRL_RESET & 32'hFFFF_FFFE);
		repeat (4) @(posedge clk);
		chk(39'(video_18bit), 39'h0);
		// TDM, eight 24-bit slots on data A; a ninth slot lies past the limit
		apb(1'b1, CTRL_OFFSET, 32'h0000_18DA);
		for (int j = 0; j < 9; j++)
			tw[j] = 24'(xs(seed));
		repeat (8) @(posedge clk);
		got.delete();
		src.send_tdm(tw);
		repeat (60) @(posedge clk);
		for (int j = 0; j < 8; j++)
			chk(pop(), {3'h0, 3'(j), 1'b1, 8'h00, tw[j]});
		chk(39'(got.size()), 39'h0);
		// Status flags, overrun clear and sent-word count
		apb(1'b0, STATUS_OFFSET, 32'h0);
		chk(39'(rd), 39'h1AB);
		apb(1'b1, CLEAR_OFFSET, 32'h1);
		apb(1'b0, STATUS_OFFSET, 32'h0);
		chk(39'(rd), 39'h0AB);
		apb(1'b0, TXCOUNT_OFFSET, 32'h0);
		chk(39'(rd), 39'(n_sent));
		give_verdict();
	end
endmodule
